// ===== logic/rpsp_pkg.sv
// Package with the shared constants and pad types of the ROM port and general pin control.
package rpsp_pkg;

  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned RESET_MIN_NS     = 1000;
  localparam int unsigned RESET_MIN_CYC    = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STRAP_SETTLE_CYC = 2;

  localparam logic [6:0]  ROM_CLK_SLOW_MHZ = 7'h1E;
  localparam logic [6:0]  ROM_CLK_FAST_MHZ = 7'h3C;

  localparam logic [15:0] ADDR_PIN_CFG     = 16'h0000;
  localparam logic [15:0] ADDR_PIN_OUT     = 16'h0004;
  localparam logic [15:0] ADDR_PIN_STAT    = 16'h0008;
  localparam logic [15:0] ADDR_ROM_CTL     = 16'h2400;

  localparam int unsigned CFG_GP1_POS      = 0;
  localparam int unsigned CFG_GP2_POS      = 2;
  localparam int unsigned CFG_GP5_POS      = 4;
  localparam logic [4:0]  CFG_RESET        = 5'h00;

  localparam int unsigned OUT_VAL_POS      = 0;
  localparam int unsigned OUT_OE_POS       = 4;
  localparam int unsigned OUT_LED_POS      = 8;
  localparam logic [8:0]  OUT_RESET        = 9'h000;

  localparam int unsigned STAT_LVL_POS     = 0;
  localparam int unsigned STAT_EDGE_POS    = 4;

  localparam int unsigned ROM_SPEED_POS    = 1;

  localparam logic [1:0]  GP1_GPIO         = 2'h0;
  localparam logic [1:0]  GP1_IRQ          = 2'h1;
  localparam logic [1:0]  GP1_LED          = 2'h2;
  localparam logic [1:0]  GP1_UART_TX      = 2'h3;
  localparam logic [1:0]  GP2_GPIO         = 2'h0;
  localparam logic [1:0]  GP2_IRQ          = 2'h1;
  localparam logic [1:0]  GP2_UART_RX      = 2'h2;
  localparam logic        GP5_GPIO         = 1'h0;
  localparam logic        GP5_TWI_DATA     = 1'h1;

  typedef struct packed {
    logic o;
    logic oe;
    logic pd_en;
  } rpsp_pad_out_t;

endpackage : rpsp_pkg

// ===== logic/rpsp_sync.sv
// Two-flop synchroniser for a group of pin inputs.
module rpsp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end

endmodule : rpsp_sync

// ===== logic/rpsp_strap_latch.sv
// Speed strap capture after reset release; the latched value then holds until the next reset.
module rpsp_strap_latch
  import rpsp_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic strap_sync,
  output logic      speed_fast,
  output logic      running
);

  typedef enum logic {RPSP_WAIT, RPSP_RUN} rpsp_strap_st_t;

  rpsp_strap_st_t state;
  rpsp_strap_st_t next_state;
  logic [1:0]     cnt;
  logic [1:0]     next_cnt;
  logic           next_speed_fast;

  // The synchroniser needs its two edges to carry a real pin sample, so capture waits for them.
  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_speed_fast = speed_fast;
    case (state)
      RPSP_WAIT: begin
        if (cnt == 2'(STRAP_SETTLE_CYC)) begin
          next_speed_fast = strap_sync;
          next_state      = RPSP_RUN;
        end else begin
          next_cnt = cnt + 2'h1;
        end
      end
      RPSP_RUN: begin
        next_state = RPSP_RUN;
      end
      default: begin
        next_state = RPSP_WAIT;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= RPSP_WAIT;
      cnt        <= 2'h0;
      speed_fast <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      speed_fast <= next_speed_fast;
    end
  end

  assign running = (state == RPSP_RUN);

  a_strap_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == RPSP_WAIT && cnt == 2'(STRAP_SETTLE_CYC)) |=> (speed_fast == $past(strap_sync) && running))
    else $error("strap value not captured at the end of the settle time");

  a_latch_stable: assert property (@(posedge hclk) disable iff (!hresetn)
    running |=> (running && $stable(speed_fast)))
    else $error("latched speed changed without a reset");

endmodule : rpsp_strap_latch

// ===== logic/rpsp_pin_control.sv
// Top of the ROM port speed strap and general pin control, with its AHB-Lite register slave.
//
// Functional notes
// - During reset the strap pin is undriven with its weak pull-down on.
// - On reset release the strap pin level is captured into the speed latch.
// - After capture the strap pin becomes ROM data output, pull-down off.
// - Latched zero selects a 30 MHz ROM clock, one selects 60 MHz.
// - Latched one leaves the strap/data pin undriven during suspend.
// - Latched zero drives the strap/data pin low throughout suspend.
// - The ROM data input pin keeps its weak pull-down on at all times.
// - General pin five serves as two-wire EEPROM data when so configured.
// - General pin one: GPIO, edge interrupt input, indicator light or UART transmit.
// - General pin two: GPIO, edge interrupt input or UART receive.
// - The latched ROM speed reads back as a bit of the ROM port control register.
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
module rpsp_pin_control
  import rpsp_pkg::*;
(
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic [31:0]        hrdata,
  output logic               hresp,
  input  wire logic          suspend,
  input  wire logic          rom_dout,
  input  wire logic          rom_dout_en,
  output logic               rom_speed_fast,
  output logic [6:0]         rom_clk_mhz,
  output logic               rom_data_rx,
  input  wire logic          rom_speed_strap_pin_level,
  output rpsp_pad_out_t      rom_speed_strap_pin,
  input  wire logic          rom_serial_data_in_level,
  output logic               rom_serial_data_in_pd_en,
  input  wire logic          uart_txd,
  output logic               uart_rxd,
  input  wire logic          twi_sda_drive_low,
  output logic               twi_sda_rx,
  input  wire logic          general_pin_one_level,
  output rpsp_pad_out_t      general_pin_one,
  input  wire logic          general_pin_two_level,
  output rpsp_pad_out_t      general_pin_two,
  input  wire logic          general_pin_five_level,
  output rpsp_pad_out_t      general_pin_five
);

  logic       strap_sync;
  logic       running;
  logic [3:0] pin_sync;
  logic       gp1_in;
  logic       gp2_in;
  logic       gp5_in;

  rpsp_sync #(.W(5)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({rom_serial_data_in_level, general_pin_five_level, general_pin_two_level, general_pin_one_level,
                rom_speed_strap_pin_level}),
    .q       ({pin_sync, strap_sync})
  );

  assign gp1_in      = pin_sync[0];
  assign gp2_in      = pin_sync[1];
  assign gp5_in      = pin_sync[2];
  assign rom_data_rx = pin_sync[3];

  rpsp_strap_latch u_strap (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .strap_sync (strap_sync),
    .speed_fast (rom_speed_fast),
    .running    (running)
  );

  // Register state.
  logic [4:0]  cfg;
  logic [8:0]  pin_out;
  logic [2:0]  edge_flag;
  logic [2:0]  in_prev;
  logic        dp_write;
  logic [15:0] dp_addr;
  logic [6:0]  next_clk_mhz;
  logic [4:0]  next_cfg;
  logic [8:0]  next_pin_out;
  logic [2:0]  next_edge_flag;
  logic [2:0]  next_in_prev;
  logic        next_dp_write;
  logic [15:0] next_dp_addr;
  logic [31:0] next_hrdata;
  logic        ap_take;
  logic [2:0]  rise;
  logic [2:0]  irq_mode;
  logic [2:0]  w1c;
  logic [1:0]  gp1_mode;
  logic [1:0]  gp2_mode;
  logic        gp5_mode;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a[15:2] == off[15:2]);
  endfunction : hit

  assign gp1_mode = cfg[CFG_GP1_POS +: 2];
  assign gp2_mode = cfg[CFG_GP2_POS +: 2];
  assign gp5_mode = cfg[CFG_GP5_POS];

  // Only word transfers exist on this bus, so byte lanes are not decoded.
  assign ap_take   = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  assign irq_mode = {1'b0, gp2_mode == GP2_IRQ, gp1_mode == GP1_IRQ};
  assign rise     = {gp5_in, gp2_in, gp1_in} & ~in_prev & irq_mode;
  assign w1c      = (dp_write && hit(dp_addr, ADDR_PIN_STAT)) ? hwdata[STAT_EDGE_POS +: 3] : 3'h0;

  always_comb begin
    next_cfg       = cfg;
    next_pin_out   = pin_out;
    next_in_prev   = {gp5_in, gp2_in, gp1_in};
    // A new edge in the cycle of its clear still leaves the flag set.
    next_edge_flag = (edge_flag & ~w1c) | rise;
    next_dp_write  = ap_take && hwrite;
    next_dp_addr   = ap_take ? haddr[15:0] : dp_addr;
    next_hrdata    = hrdata;
    next_clk_mhz   = rom_speed_fast ? ROM_CLK_FAST_MHZ : ROM_CLK_SLOW_MHZ;
    if (dp_write && hit(dp_addr, ADDR_PIN_CFG)) begin
      next_cfg = hwdata[4:0];
    end
    if (dp_write && hit(dp_addr, ADDR_PIN_OUT)) begin
      next_pin_out = hwdata[8:0];
    end
    if (ap_take && !hwrite) begin
      next_hrdata = 32'h0000_0000;
      if (hit(haddr[15:0], ADDR_PIN_CFG)) begin
        next_hrdata[4:0] = cfg;
      end
      if (hit(haddr[15:0], ADDR_PIN_OUT)) begin
        next_hrdata[8:0] = pin_out;
      end
      if (hit(haddr[15:0], ADDR_PIN_STAT)) begin
        next_hrdata[STAT_LVL_POS +: 3]  = {gp5_in, gp2_in, gp1_in};
        next_hrdata[STAT_EDGE_POS +: 3] = edge_flag;
      end
      if (hit(haddr[15:0], ADDR_ROM_CTL)) begin
        next_hrdata[ROM_SPEED_POS] = rom_speed_fast;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg         <= CFG_RESET;
      pin_out     <= OUT_RESET;
      edge_flag   <= 3'h0;
      in_prev     <= 3'h0;
      dp_write    <= 1'b0;
      dp_addr     <= 16'h0000;
      hrdata      <= 32'h0000_0000;
      rom_clk_mhz <= ROM_CLK_SLOW_MHZ;
    end else begin
      cfg         <= next_cfg;
      pin_out     <= next_pin_out;
      edge_flag   <= next_edge_flag;
      in_prev     <= next_in_prev;
      dp_write    <= next_dp_write;
      dp_addr     <= next_dp_addr;
      hrdata      <= next_hrdata;
      rom_clk_mhz <= next_clk_mhz;
    end
  end

  // Pad steering.
  always_comb begin
    rom_speed_strap_pin = '{o: 1'b0, oe: 1'b0, pd_en: 1'b1};
    if (running) begin
      rom_speed_strap_pin.pd_en = 1'b0;
      if (suspend) begin
        // A fast strap has an external pull-up, so driving low would burn current against it.
        rom_speed_strap_pin.oe = !rom_speed_fast;
      end else begin
        rom_speed_strap_pin.o  = rom_dout;
        rom_speed_strap_pin.oe = rom_dout_en;
      end
    end
  end

  assign rom_serial_data_in_pd_en = 1'b1;

  always_comb begin
    general_pin_one = '{o: pin_out[OUT_VAL_POS], oe: pin_out[OUT_OE_POS], pd_en: 1'b0};
    case (gp1_mode)
      GP1_IRQ:     general_pin_one.oe = 1'b0;
      GP1_LED:     general_pin_one = '{o: pin_out[OUT_LED_POS], oe: 1'b1, pd_en: 1'b0};
      GP1_UART_TX: general_pin_one = '{o: uart_txd, oe: 1'b1, pd_en: 1'b0};
      default:     general_pin_one.oe = pin_out[OUT_OE_POS];
    endcase
  end

  always_comb begin
    general_pin_two = '{o: pin_out[OUT_VAL_POS + 1], oe: pin_out[OUT_OE_POS + 1], pd_en: 1'b0};
    uart_rxd        = 1'b1;
    case (gp2_mode)
      GP2_IRQ:     general_pin_two.oe = 1'b0;
      GP2_UART_RX: begin
        general_pin_two.oe = 1'b0;
        uart_rxd           = gp2_in;
      end
      default:     general_pin_two.oe = pin_out[OUT_OE_POS + 1];
    endcase
  end

  // The two-wire data line is open drain: it only ever pulls low.
  always_comb begin
    general_pin_five = '{o: pin_out[OUT_VAL_POS + 2], oe: pin_out[OUT_OE_POS + 2], pd_en: 1'b0};
    twi_sda_rx       = 1'b1;
    if (gp5_mode == GP5_TWI_DATA) begin
      general_pin_five = '{o: 1'b0, oe: twi_sda_drive_low, pd_en: 1'b0};
      twi_sda_rx       = gp5_in;
    end
  end

  a_strap_reset_hiz: assert property (@(posedge hclk) disable iff (!hresetn)
    !running |-> (!rom_speed_strap_pin.oe && rom_speed_strap_pin.pd_en))
    else $error("strap pin driven or pull-down off before capture");

  a_dout_after_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    (running && !suspend) |-> (!rom_speed_strap_pin.pd_en && rom_speed_strap_pin.o == rom_dout
      && rom_speed_strap_pin.oe == rom_dout_en))
    else $error("strap pin not serving as ROM data output");

  a_speed_clock_map: assert property (@(posedge hclk) disable iff (!hresetn)
    running ##1 running |-> (rom_clk_mhz == (rom_speed_fast ? 7'h3C : 7'h1E)))
    else $error("ROM clock rate does not match latched speed");

  a_suspend_hiz: assert property (@(posedge hclk) disable iff (!hresetn)
    (running && suspend && rom_speed_fast) |-> !rom_speed_strap_pin.oe)
    else $error("strap pin driven in suspend with fast strap");

  a_suspend_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (running && suspend && !rom_speed_fast) |-> (rom_speed_strap_pin.oe && !rom_speed_strap_pin.o))
    else $error("strap pin not driven low in suspend with slow strap");

  a_din_pulldown: assert property (@(posedge hclk) disable iff (!hresetn)
    rom_serial_data_in_pd_en)
    else $error("ROM data input pull-down dropped");

  a_twi_open_drain: assert property (@(posedge hclk) disable iff (!hresetn)
    (gp5_mode == GP5_TWI_DATA) |-> (!general_pin_five.o && general_pin_five.oe == twi_sda_drive_low
      && twi_sda_rx == gp5_in))
    else $error("two-wire data line not open drain");

  a_uart_tx_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    (gp1_mode == GP1_UART_TX) |-> (general_pin_one.oe && general_pin_one.o == uart_txd))
    else $error("general pin one not carrying UART transmit");

  a_uart_rx_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    (gp2_mode == GP2_UART_RX) |-> (!general_pin_two.oe && uart_rxd == gp2_in))
    else $error("general pin two not feeding UART receive");

  a_speed_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    (ap_take && !hwrite && hit(haddr[15:0], ADDR_ROM_CTL) && running)
      |=> (hrdata == {30'h0, rom_speed_fast, 1'b0}))
    else $error("ROM port control read does not show latched speed");

  a_edge_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (rise[0] && gp1_mode == GP1_IRQ) |=> edge_flag[0])
    else $error("edge on general pin one lost");

  // Set beats clear, so a clear with no new edge must empty the flag one edge later.
  a_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (w1c[0] && !rise[0]) |=> !edge_flag[0])
    else $error("edge flag of pin one not cleared");

  a_edge_pin_two: assert property (@(posedge hclk) disable iff (!hresetn)
    (rise[1] && gp2_mode == GP2_IRQ) |=> edge_flag[1])
    else $error("edge on general pin two lost");

  a_no_flag_five: assert property (@(posedge hclk) disable iff (!hresetn)
    !edge_flag[2])
    else $error("general pin five raised an edge flag");

  a_irq_one_input: assert property (@(posedge hclk) disable iff (!hresetn)
    (gp1_mode == GP1_IRQ) |-> !general_pin_one.oe)
    else $error("general pin one driven in interrupt mode");

  a_irq_two_input: assert property (@(posedge hclk) disable iff (!hresetn)
    (gp2_mode == GP2_IRQ) |-> !general_pin_two.oe)
    else $error("general pin two driven in interrupt mode");

  a_led_pin_one: assert property (@(posedge hclk) disable iff (!hresetn)
    (gp1_mode == GP1_LED) |-> (general_pin_one.oe && general_pin_one.o == pin_out[OUT_LED_POS]))
    else $error("general pin one not showing the indicator level");

  a_gpio_pin_one: assert property (@(posedge hclk) disable iff (!hresetn)
    (gp1_mode == GP1_GPIO) |-> (general_pin_one.o == pin_out[OUT_VAL_POS]
      && general_pin_one.oe == pin_out[OUT_OE_POS]))
    else $error("general pin one not following its output register");

  a_rx_idle_high: assert property (@(posedge hclk) disable iff (!hresetn)
    (gp2_mode != GP2_UART_RX) |-> uart_rxd)
    else $error("UART receive not idle outside receive mode");

endmodule : rpsp_pin_control

// ===== tb/rpsp_board_model.sv
// Board side of the strap pin and the serial ROM data line.
module rpsp_board_model
  import rpsp_pkg::*;
(
  input  wire logic          strap_fast,
  input  wire rpsp_pad_out_t strap_pad,
  input  wire logic          rom_drive,
  input  wire logic          rom_bit,
  input  wire logic          di_pd_en,
  output logic               strap_pin,
  output logic               rom_di
);
  timeunit 1ns;
  timeprecision 1ps;

  logic last_strap = 1'b0;
  logic last_di    = 1'b0;

  // A line with nothing holding it shows the inverse of its last level, so a lost pull is never hidden.
  always_comb begin
    if (strap_pad.oe) strap_pin = strap_pad.o;
    else if (strap_fast) strap_pin = 1'b1;
    else if (strap_pad.pd_en) strap_pin = 1'b0;
    else strap_pin = ~last_strap;
  end

  always_comb begin
    if (rom_drive) rom_di = rom_bit;
    else if (di_pd_en) rom_di = 1'b0;
    else rom_di = ~last_di;
  end

  always @(strap_pin) if (strap_pad.oe || strap_fast || strap_pad.pd_en) last_strap = strap_pin;
  always @(rom_di) if (rom_drive || di_pd_en) last_di = rom_di;
endmodule : rpsp_board_model

// ===== tb/tb_rpsp_pin_control.sv
// Self-checking bench for the ROM port strap and general pin control.
module tb_rpsp_pin_control import rpsp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic          hclk = 1'b0;
  logic          hresetn = 1'b0;
  logic          hsel = 1'b0;
  logic [31:0]   haddr = 32'h0;
  logic [1:0]    htrans = 2'h0;
  logic          hwrite = 1'b0;
  logic [31:0]   hwdata = 32'h0;
  logic          hreadyout, hresp, rom_speed_fast, rom_data_rx, di_pd, uart_rxd, twi_sda_rx;
  logic [31:0]   hrdata;
  logic [6:0]    rom_clk_mhz;
  logic          suspend = 1'b0, rom_dout = 1'b0, rom_dout_en = 1'b0, uart_txd = 1'b1, sda_low = 1'b0;
  logic          g1_ext = 1'b0, g2_ext = 1'b1, g5_ext = 1'b1;
  logic          strap_fast = 1'b0, rom_drive = 1'b0, rom_bit = 1'b0, strap_pin, rom_di;
  rpsp_pad_out_t strap_pad, g1, g2, g5;
  int            fails = 0, tests_run = 0, cycles = 0;
  logic [31:0]   d;

  always #10 hclk = ~hclk;

  rpsp_pin_control DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .suspend(suspend), .rom_dout(rom_dout), .rom_dout_en(rom_dout_en),
    .rom_speed_fast(rom_speed_fast), .rom_clk_mhz(rom_clk_mhz), .rom_data_rx(rom_data_rx),
    .rom_speed_strap_pin_level(strap_pin), .rom_speed_strap_pin(strap_pad),
    .rom_serial_data_in_level(rom_di),
    .rom_serial_data_in_pd_en(di_pd), .uart_txd(uart_txd), .uart_rxd(uart_rxd),
    .twi_sda_drive_low(sda_low), .twi_sda_rx(twi_sda_rx),
    .general_pin_one_level(g1.oe ? g1.o : g1_ext),
    .general_pin_one(g1), .general_pin_two_level(g2.oe ? g2.o : g2_ext), .general_pin_two(g2),
    .general_pin_five_level(g5.oe ? g5.o : g5_ext), .general_pin_five(g5));

  rpsp_board_model board (
    .strap_fast(strap_fast), .strap_pad(strap_pad), .rom_drive(rom_drive), .rom_bit(rom_bit),
    .di_pd_en(di_pd), .strap_pin(strap_pin), .rom_di(rom_di));

  task automatic stop_test;
    $display("checks %0d, wrong %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk

  // One single word transfer; the master waits for hready at each phase.
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {16'h0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : xfer

  task automatic step(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask : step

  task automatic t_strap(input logic fast);
    @(posedge hclk);
    strap_fast <= fast;
    hresetn <= 1'b0;
    rom_dout_en <= 1'b0;
    step(RESET_MIN_CYC);
    chk({strap_pad.oe, strap_pad.pd_en}, 32'h1, "strap pad in reset");
    @(posedge hclk);
    hresetn <= 1'b1;
    step(4);
    chk(rom_speed_fast, fast, "latched speed");
    chk(rom_clk_mhz, fast ? ROM_CLK_FAST_MHZ : ROM_CLK_SLOW_MHZ, "rom clock");
    chk(strap_pad.pd_en, 32'h0, "strap pull-down after reset");
    xfer(1'b0, ADDR_ROM_CTL, 32'h0);
    chk(d, 32'(fast) << ROM_SPEED_POS, "speed bit");
    xfer(1'b1, ADDR_ROM_CTL, 32'h0);
    xfer(1'b0, ADDR_ROM_CTL, 32'h0);
    chk(d, 32'(fast) << ROM_SPEED_POS, "speed bit read-only");
    rom_dout_en <= 1'b1;
    rom_dout <= 1'b1;
    step(1);
    chk({strap_pad.o, strap_pad.oe}, 32'h3, "data out on strap pin");
    @(posedge hclk);
    suspend <= 1'b1;
    strap_fast <= ~fast;
    step(3);
    chk(strap_pad.oe, !fast, "suspend drive");
    if (!fast) chk(strap_pad.o, 32'h0, "suspend low");
    @(posedge hclk);
    suspend <= 1'b0;
    rom_drive <= 1'b1;
    rom_bit <= 1'b1;
    step(4);
    chk(rom_speed_fast, fast, "no recapture on resume");
    chk(rom_data_rx, 32'h1, "rom data in");
    @(posedge hclk);
    rom_drive <= 1'b0;
    step(4);
    chk({rom_data_rx, di_pd}, 32'h1, "rom data in pulled low");
    $display("done strap %0d", fast);
  endtask : t_strap

  task automatic t_pin_one;
    xfer(1'b1, ADDR_PIN_OUT, 32'h77);
    step(0);
    chk({g1.o, g1.oe, g1.pd_en}, 32'h6, "gpio out");
    chk({g2.o, g2.oe, g2.pd_en}, 32'h6, "pin two gpio out");
    chk({g5.o, g5.oe, g5.pd_en}, 32'h6, "pin five gpio out");
    xfer(1'b1, ADDR_PIN_CFG, 32'(GP1_LED));
    xfer(1'b1, ADDR_PIN_OUT, 32'h100);
    step(0);
    chk({g1.o, g1.oe}, 32'h3, "indicator");
    xfer(1'b1, ADDR_PIN_CFG, 32'(GP1_UART_TX));
    uart_txd <= 1'b0;
    step(1);
    chk({g1.o, g1.oe}, 32'h1, "uart tx");
    xfer(1'b1, ADDR_PIN_OUT, 32'h0);
    xfer(1'b1, ADDR_PIN_CFG, 32'(GP1_IRQ));
    g1_ext <= 1'b1;
    step(6);
    xfer(1'b0, ADDR_PIN_STAT, 32'h0);
    chk(d & 32'h11, 32'h11, "pin one edge flag");
    xfer(1'b1, ADDR_PIN_STAT, 32'h10);
    xfer(1'b0, ADDR_PIN_STAT, 32'h0);
    chk(d & 32'h10, 32'h0, "flag cleared");
    $display("done pin one");
  endtask : t_pin_one

  task automatic t_pin_two;
    xfer(1'b1, ADDR_PIN_CFG, 32'(GP2_UART_RX) << CFG_GP2_POS);
    g2_ext <= 1'b0;
    step(4);
    chk({uart_rxd, g2.oe}, 32'h0, "uart rx follows pin");
    xfer(1'b1, ADDR_PIN_CFG, 32'(GP2_GPIO) << CFG_GP2_POS);
    step(0);
    chk(uart_rxd, 32'h1, "uart rx idle off mode");
    xfer(1'b1, ADDR_PIN_CFG, 32'(GP2_IRQ) << CFG_GP2_POS);
    g2_ext <= 1'b1;
    step(6);
    xfer(1'b0, ADDR_PIN_STAT, 32'h0);
    chk(d & 32'h22, 32'h22, "pin two edge flag");
    $display("done pin two");
  endtask : t_pin_two

  task automatic t_pin_five;
    xfer(1'b1, ADDR_PIN_CFG, 32'(GP5_TWI_DATA) << CFG_GP5_POS);
    sda_low <= 1'b1;
    step(4);
    chk({g5.o, g5.oe, twi_sda_rx}, 32'h2, "sda pulled low");
    @(posedge hclk);
    sda_low <= 1'b0;
    step(4);
    chk({g5.oe, twi_sda_rx}, 32'h1, "sda released");
    @(posedge hclk);
    g5_ext <= 1'b0;
    step(4);
    chk(twi_sda_rx, 32'h0, "sda from eeprom");
    xfer(1'b0, 16'h0100, 32'h0);
    chk(d, 32'h0, "unmapped read");
    chk(hresp, 32'h0, "okay response");
    $display("done pin five");
  endtask : t_pin_five

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    t_strap(1'b0);
    t_strap(1'b1);
    t_pin_one();
    t_pin_two();
    t_pin_five();
    stop_test();
  end
endmodule : tb_rpsp_pin_control
